// >>> rtl/ivp_pkg.sv
// Purpose: constants for the interrupt vector and priority map
// Assumes: one system clock, synchronous active-high reset
// Notes:   vector addresses are 16-bit byte addresses of the table
package ivp_pkg;
	localparam int                NUM_MASKABLE   = 23;
	localparam int                PRIO_WIDTH     = 5;
	localparam int                VEC_WIDTH      = 16;
	localparam logic [15:0]       VEC_WATCHDOG   = 16'h0004;
	localparam logic [15:0]       VEC_BREAK      = 16'h003E;
	localparam logic [15:0]       VEC_FIRST_MASK = 16'h0004;
	localparam logic [15:0]       VEC_STEP       = 16'h0002;
	localparam logic [15:0]       VEC_NONE       = 16'h0000;
	localparam int                PRIO_WATCHDOG  = 0;
	localparam int                PRIO_PIN_FIRST = 1;
	localparam int                PRIO_SERIAL0   = 9;
	localparam int                PRIO_SERIAL1   = 10;
	localparam int                PRIO_SERIAL3   = 11;
	localparam int                PRIO_TIMER_A   = 12;
	localparam int                PRIO_TIMER_B   = 13;
	localparam int                PRIO_ASYNC_ERR = 14;
	localparam int                PRIO_ASYNC_RX  = 15;
	localparam int                PRIO_ASYNC_TX  = 16;
	localparam int                PRIO_BASIC     = 17;
	localparam int                PRIO_WIDE0     = 18;
	localparam int                PRIO_WIDE1     = 19;
	localparam int                PRIO_HB_DATA   = 20;
	localparam int                PRIO_HB_STAT   = 21;
	localparam int                PRIO_CONV      = 22;
	localparam int                NUM_PINS       = 8;
	localparam logic [1:0]        WDT_MODE_INTERVAL = 2'h0;
	localparam logic [1:0]        WDT_MODE_ONE      = 2'h1;
	// vector kind reported to the core
	typedef enum logic [1:0] {
		IVP_KIND_NONE,
		IVP_KIND_NMI,
		IVP_KIND_MASKABLE,
		IVP_KIND_BREAK
	} ivp_kind_t;
endpackage

// >>> rtl/ivp_arb_if.sv
// Purpose: carries pending requests to the arbiter and its result back
// Assumes: single clock domain
// Notes:   arbiter is purely combinational
`timescale 1ns/1ns
`default_nettype none
interface ivp_arb_if;
	logic [ivp_pkg::NUM_MASKABLE-1:0] pending;
	logic                             found;
	logic [ivp_pkg::PRIO_WIDTH-1:0]   winner;
	modport owner (output pending, input found, input winner);
	modport arbiter (input pending, output found, output winner);
endinterface
`default_nettype wire

// >>> rtl/ivp_arbiter.sv
// Purpose: fixed-priority pick among pending maskable requests
// Assumes: bit index equals default priority
// Notes:   bit 0 is the highest priority
`timescale 1ns/1ns
`default_nettype none
module ivp_arbiter (
	ivp_arb_if.arbiter arb
);
	// scan from lowest priority upward so the smallest index wins
	always_comb begin
		arb.found  = 1'b0;
		arb.winner = '0;
		for (int i = ivp_pkg::NUM_MASKABLE - 1; i >= 0; i--) begin
			if (arb.pending[i]) begin
				arb.found  = 1'b1;
				arb.winner = i[ivp_pkg::PRIO_WIDTH-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/ivp_map.sv
// Purpose: interrupt source table, pending latches and vector selection
// Assumes: source pulses come from logic on clk_i; pin edges are
//          asynchronous levels detected here
// Notes:   one vector offered at a time, held until acknowledged
`timescale 1ns/1ns
`default_nettype none
module ivp_map #(
	parameter bit HAS_ASYNC_SERIAL = 1'b1,
	parameter bit HAS_HOME_BUS     = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [1:0]  watchdog_mode_i,
	input  wire logic        watchdog_overflow_request_i,
	input  wire logic [7:0]  pin_edge_level_i,
	input  wire logic        clocked_serial_zero_done_i,
	input  wire logic        clocked_serial_one_done_i,
	input  wire logic        clocked_serial_three_done_i,
	input  wire logic        byte_timer_a_match_i,
	input  wire logic        byte_timer_b_match_i,
	input  wire logic        async_rx_error_i,
	input  wire logic        async_rx_done_i,
	input  wire logic        async_tx_done_i,
	input  wire logic        basic_timer_match_request_i,
	input  wire logic        wide_timer_channel_zero_request_i,
	input  wire logic        wide_timer_channel_one_request_i,
	input  wire logic        home_bus_data_request_i,
	input  wire logic        home_bus_status_request_i,
	input  wire logic        conversion_done_request_i,
	input  wire logic        software_break_instruction_i,
	input  wire logic        ack_i,
	output logic             request_o,
	output logic [1:0]       kind_o,
	output logic [15:0]      vector_o,
	output logic [4:0]       priority_o,
	output logic [22:0]      pending_o
);
	////////////////////////////////////////////////////////////////////
	typedef ivp_pkg::ivp_kind_t ivp_kind_t;

	typedef struct packed {
		logic [ivp_pkg::NUM_PINS-1:0]     pin_meta;
		logic [ivp_pkg::NUM_PINS-1:0]     pin_sync;
		logic [ivp_pkg::NUM_PINS-1:0]     pin_prev;
		logic [ivp_pkg::NUM_MASKABLE-1:0] pending;
		logic                             nmi_pending;
		logic                             break_pending;
		logic                             request;
		ivp_kind_t                        kind;
		logic [ivp_pkg::VEC_WIDTH-1:0]    vector;
		logic [ivp_pkg::PRIO_WIDTH-1:0]   prio;
	} ivp_state_t;

	ivp_state_t                       st;
	ivp_state_t                       next_st;
	logic [ivp_pkg::NUM_MASKABLE-1:0] raw;
	logic [ivp_pkg::NUM_PINS-1:0]     pin_rise;
	logic                             nmi_raw;

	ivp_arb_if arb ();

	ivp_arbiter u_arbiter (
		.arb (arb)
	);

	////////////////////////////////////////////////////////////////////
	// map each maskable source onto its default priority bit, the mode-one watchdog onto nmi_raw
	always_comb begin
		raw      = '0;
		pin_rise = st.pin_sync & ~st.pin_prev; // rising edge, synced
		nmi_raw  = watchdog_overflow_request_i
			&& (watchdog_mode_i == ivp_pkg::WDT_MODE_ONE);
		raw[ivp_pkg::PRIO_WATCHDOG] = watchdog_overflow_request_i
			&& (watchdog_mode_i == ivp_pkg::WDT_MODE_INTERVAL);
		raw[ivp_pkg::PRIO_PIN_FIRST +: ivp_pkg::NUM_PINS] = pin_rise;
		raw[ivp_pkg::PRIO_SERIAL0] = clocked_serial_zero_done_i;
		raw[ivp_pkg::PRIO_SERIAL1] = clocked_serial_one_done_i;
		raw[ivp_pkg::PRIO_SERIAL3] = clocked_serial_three_done_i;
		raw[ivp_pkg::PRIO_TIMER_A] = byte_timer_a_match_i;
		raw[ivp_pkg::PRIO_TIMER_B] = byte_timer_b_match_i;
		// async serial slots are empty in the reduced variant
		raw[ivp_pkg::PRIO_ASYNC_ERR] = HAS_ASYNC_SERIAL
			&& async_rx_error_i;
		raw[ivp_pkg::PRIO_ASYNC_RX]  = HAS_ASYNC_SERIAL
			&& async_rx_done_i;
		raw[ivp_pkg::PRIO_ASYNC_TX]  = HAS_ASYNC_SERIAL
			&& async_tx_done_i;
		raw[ivp_pkg::PRIO_BASIC] = basic_timer_match_request_i;
		raw[ivp_pkg::PRIO_WIDE0] = wide_timer_channel_zero_request_i;
		raw[ivp_pkg::PRIO_WIDE1] = wide_timer_channel_one_request_i;
		raw[ivp_pkg::PRIO_HB_DATA] = HAS_HOME_BUS
			&& home_bus_data_request_i;
		raw[ivp_pkg::PRIO_HB_STAT] = HAS_HOME_BUS
			&& home_bus_status_request_i;
		raw[ivp_pkg::PRIO_CONV] = conversion_done_request_i;
	end

	assign arb.pending = st.pending;

	////////////////////////////////////////////////////////////////////
	// latch requests, offer one vector, clear the taken one on ack
	always_comb begin
		next_st          = st;
		next_st.pin_meta = pin_edge_level_i;
		next_st.pin_sync = st.pin_meta;
		next_st.pin_prev = st.pin_sync;
		// retire the offered source; a new event in the same cycle wins
		if (st.request && ack_i) begin
			next_st.request = 1'b0;
			case (st.kind)
				ivp_pkg::IVP_KIND_NMI:      next_st.nmi_pending = 1'b0;
				ivp_pkg::IVP_KIND_BREAK:    next_st.break_pending = 1'b0;
				ivp_pkg::IVP_KIND_MASKABLE: next_st.pending[st.prio] = 1'b0;
				default:                    next_st.request = 1'b0;
			endcase
		end
		next_st.pending     = next_st.pending | raw;
		next_st.nmi_pending = next_st.nmi_pending | nmi_raw;
		next_st.break_pending = next_st.break_pending
			| software_break_instruction_i;
		// pick a new offer when none is outstanding or the outstanding one is acknowledged
		if (!st.request || ack_i) begin
			next_st.request = 1'b0;
			next_st.kind    = ivp_pkg::IVP_KIND_NONE;
			next_st.vector  = ivp_pkg::VEC_NONE;
			next_st.prio    = '0;
			if (st.nmi_pending && !(st.request && ack_i
				&& st.kind == ivp_pkg::IVP_KIND_NMI)) begin
				next_st.request = 1'b1;
				next_st.kind    = ivp_pkg::IVP_KIND_NMI;
				next_st.vector  = ivp_pkg::VEC_WATCHDOG;
			end else if (st.break_pending && !(st.request && ack_i
				&& st.kind == ivp_pkg::IVP_KIND_BREAK)) begin
				next_st.request = 1'b1;
				next_st.kind    = ivp_pkg::IVP_KIND_BREAK;
				next_st.vector  = ivp_pkg::VEC_BREAK;
			end else if (arb.found && !(st.request && ack_i
				&& st.kind == ivp_pkg::IVP_KIND_MASKABLE
				&& st.prio == arb.winner)) begin
				next_st.request = 1'b1;
				next_st.kind    = ivp_pkg::IVP_KIND_MASKABLE;
				next_st.prio    = arb.winner;
				next_st.vector  = ivp_pkg::VEC_FIRST_MASK
					+ ivp_pkg::VEC_STEP
					* {11'h000, arb.winner};
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign request_o  = st.request;
	assign kind_o     = st.kind;
	assign vector_o   = st.vector;
	assign priority_o = st.prio;
	assign pending_o  = st.pending;
endmodule
`default_nettype wire

// >>> verif/ivp_map_monitor.sv
// Purpose: port checks on the vector map
// Assumes: one clock, sync active-high reset
// Notes:   bound into every ivp_map
`timescale 1ns/1ns
`default_nettype none
module ivp_map_monitor (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [1:0]  watchdog_mode_i,
	input wire logic        watchdog_overflow_request_i,
	input wire logic        byte_timer_a_match_i,
	input wire logic        conversion_done_request_i,
	input wire logic        ack_i,
	input wire logic        request_o,
	input wire logic [1:0]  kind_o,
	input wire logic [15:0] vector_o,
	input wire logic [4:0]  priority_o,
	input wire logic [22:0] pending_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////////
	// source pulses reach their pending bit; a mode-one watchdog does not set bit 0
	AST_TIMER_A: assert property (byte_timer_a_match_i |=> pending_o[12])
		else $error("timer a not pending");
	AST_CONV: assert property (conversion_done_request_i |=> pending_o[22])
		else $error("conversion not pending");
	AST_WDT_INT: assert property (
		watchdog_overflow_request_i && watchdog_mode_i == 2'h0
		|=> pending_o[0])
		else $error("interval watchdog not pending");
	AST_WDT_NMI: assert property (
		watchdog_overflow_request_i && watchdog_mode_i == 2'h1
		&& !pending_o[0] |=> !pending_o[0])
		else $error("mode one watchdog went maskable");
	// offered vectors follow the table
	AST_MASK_VEC: assert property (
		request_o && kind_o == 2'h2
		|-> vector_o == 16'h0004 + {10'h000, priority_o, 1'b0})
		else $error("maskable vector wrong");
	AST_NMI_VEC: assert property (
		request_o && kind_o == 2'h1 |-> vector_o == 16'h0004)
		else $error("nmi vector wrong");
	AST_BREAK_VEC: assert property (
		request_o && kind_o == 2'h3 |-> vector_o == 16'h003E)
		else $error("break vector wrong");
	// winner is the lowest pending number
	AST_WIN: assert property (
		$rose(request_o) && kind_o == 2'h2
		|-> ($past(pending_o) & ~({23{1'b1}} << priority_o)) == 23'h0)
		else $error("higher request was pending");
	// offers stand and pending bit 12 clears only on acknowledge
	AST_STAND: assert property (
		request_o && !ack_i |=> request_o && $stable(vector_o))
		else $error("offer dropped");
	AST_CLEAR: assert property ($fell(pending_o[12]) |-> $past(ack_i))
		else $error("pending lost");
	COV_NMI: cover property (request_o && kind_o == 2'h1);
	COV_BREAK: cover property (request_o && kind_o == 2'h3);
	COV_LOW: cover property (request_o && priority_o == 5'h16);
endmodule
bind ivp_map ivp_map_monitor i_ivp_map_monitor (.*);
`default_nettype wire

// >>> verif/ivp_core_model.sv
// Purpose: core side that accepts offered vectors
// Assumes: one clock, sync active-high reset
// Notes:   acknowledges after a set wait, records vectors
`timescale 1ns/1ns
`default_nettype none
module ivp_core_model (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        offer_i,
	input  wire logic [15:0] vector_i,
	input  wire logic [3:0]  delay_i,
	output logic             ack_o,
	output logic [15:0]      taken_o,
	output int               count_o
);
	logic [3:0] wait_cnt;
	////////////////////////////////////////////////////////////////////
	// wait, ack one cycle, fetch vector at the ack edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ack_o <= 1'b0;
			wait_cnt <= 4'h0;
			count_o <= 0;
		end else if (ack_o) begin
			ack_o <= 1'b0;
			wait_cnt <= 4'h0;
			taken_o <= vector_i;
			count_o <= count_o + 1;
		end else if (offer_i) begin
			if (wait_cnt >= delay_i)
				ack_o <= 1'b1;
			else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> verif/interrupt_vector_priority_map_tb_top.sv
// Purpose: self-checking bench for the vector map
// Assumes: core model acknowledges offers
// Notes:   src bit n drives the source of priority n
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_priority_map_tb_top;
	logic        clk_i, reset_i, sw_break, ack, req, lite_req;
	logic [1:0]  wmode;
	logic [22:0] src, pend, lite_pend;
	logic [3:0]  dly;
	logic [15:0] vec, taken;
	int          count, errors, n_tests;
	ivp_map i_ivp_map (.clk_i(clk_i), .reset_i(reset_i),
		.watchdog_mode_i(wmode), .watchdog_overflow_request_i(src[0]),
		.pin_edge_level_i(src[8:1]), .clocked_serial_zero_done_i(src[9]),
		.clocked_serial_one_done_i(src[10]),
		.clocked_serial_three_done_i(src[11]),
		.byte_timer_a_match_i(src[12]), .byte_timer_b_match_i(src[13]),
		.async_rx_error_i(src[14]), .async_rx_done_i(src[15]),
		.async_tx_done_i(src[16]), .basic_timer_match_request_i(src[17]),
		.wide_timer_channel_zero_request_i(src[18]),
		.wide_timer_channel_one_request_i(src[19]),
		.home_bus_data_request_i(src[20]),
		.home_bus_status_request_i(src[21]),
		.conversion_done_request_i(src[22]),
		.software_break_instruction_i(sw_break), .ack_i(ack),
		.request_o(req), .kind_o(), .vector_o(vec), .priority_o(),
		.pending_o(pend));
	// reduced variant, acknowledging its own offers
	ivp_map #(.HAS_ASYNC_SERIAL(1'b0), .HAS_HOME_BUS(1'b0)) i_ivp_map_lite (
		.clk_i(clk_i), .reset_i(reset_i),
		.watchdog_mode_i(wmode), .watchdog_overflow_request_i(src[0]),
		.pin_edge_level_i(src[8:1]), .clocked_serial_zero_done_i(src[9]),
		.clocked_serial_one_done_i(src[10]),
		.clocked_serial_three_done_i(src[11]),
		.byte_timer_a_match_i(src[12]), .byte_timer_b_match_i(src[13]),
		.async_rx_error_i(src[14]), .async_rx_done_i(src[15]),
		.async_tx_done_i(src[16]), .basic_timer_match_request_i(src[17]),
		.wide_timer_channel_zero_request_i(src[18]),
		.wide_timer_channel_one_request_i(src[19]),
		.home_bus_data_request_i(src[20]),
		.home_bus_status_request_i(src[21]),
		.conversion_done_request_i(src[22]),
		.software_break_instruction_i(sw_break), .ack_i(lite_req),
		.request_o(lite_req), .kind_o(), .vector_o(), .priority_o(),
		.pending_o(lite_pend));
	ivp_core_model i_ivp_core_model (.clk_i(clk_i), .reset_i(reset_i),
		.offer_i(req), .vector_i(vec), .delay_i(dly), .ack_o(ack),
		.taken_o(taken), .count_o(count));
	////////////////////////////////////////////////////////////////////
	// shared compare, stimulus and fetch helpers
	task automatic chk(input string what, input logic [15:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bits(input string what, input logic [22:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic fire(input logic [22:0] m, input logic b);
		@(posedge clk_i);
		src <= m;
		sw_break <= b;
		@(posedge clk_i);
		src <= 23'h0;
		sw_break <= 1'b0;
	endtask
	task automatic fetch(input logic [15:0] exp);
		int old;
		old = count;
		for (int k = 0; k < 60 && count == old; k++) @(posedge clk_i);
		#1 chk("vector", exp, count == old ? 16'hFFFF : taken);
	endtask
	task automatic close_out;
		$display("counts errors %0d checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// clock, watchdog and test sequence
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#20000;
		errors++;
		close_out;
	end
	initial begin
		reset_i  <= 1'b1;
		sw_break <= 1'b0;
		wmode    <= 2'h0;
		src      <= 23'h000000;
		dly      <= 4'h0;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		// each source alone
		for (int p = 0; p < 23; p++) begin
			fire(23'h000001 << p, 1'b0);
			fetch(16'(4 + 2 * p));
		end
		$display("test map done");
		// all at once, slow core: served in priority order
		@(posedge clk_i);
		dly <= 4'h5;
		fire({23{1'b1}}, 1'b0);
		for (int p = 0; p < 23; p++) fetch(16'(4 + 2 * p));
		chk_bits("pending", 23'h000000, pend);
		$display("test priority done");
		// timer b plus the slots that only the full variant carries
		fire(23'h31E000, 1'b0);
		#1 chk_bits("full pending", 23'h31E000, pend);
		chk_bits("lite pending", 23'h002000, lite_pend);
		fetch(16'h001E);
		fetch(16'h0020);
		fetch(16'h0022);
		fetch(16'h0024);
		fetch(16'h002C);
		fetch(16'h002E);
		$display("test variant done");
		// nmi and break ahead of maskable
		@(posedge clk_i);
		wmode <= 2'h1;
		dly <= 4'h2;
		fire(23'h400001, 1'b1);
		fetch(16'h0004);
		fetch(16'h003E);
		fetch(16'h0030);
		chk_bits("pending", 23'h000000, pend);
		$display("test nmi done");
		close_out;
	end
endmodule
`default_nettype wire
